// File: rtl/dpp_beat_ram.v
`timescale 1ns/10ps
`include "dpp_map.vh"
module dpp_beat_ram (
  // Clock
  input  wire                         clk,
  // Write port, one enable per dword lane
  input  wire [`DPP_WIDTH-1:0]        wrEn,
  input  wire [`DPP_BEAT_AW-1:0]      wrAddr,
  input  wire [`DPP_DATA_W-1:0]       wrData,
  // Asynchronous read port
  input  wire [`DPP_BEAT_AW-1:0]      rdAddr,
  output wire [`DPP_DATA_W-1:0]       rdData
);

  genvar lane;
  generate
    for (lane = 0; lane < `DPP_WIDTH; lane = lane + 1) begin : gLane
      // One array per lane keeps a single writer on every storage word
      reg [31:0] laneMem [0:(1<<`DPP_BEAT_AW)-1];
      always @(posedge clk) begin
        if (wrEn[lane])
          laneMem[wrAddr] <= wrData[lane*32 +: 32];
      end
      // Combinational read lets a beat be presented in the cycle it is chosen
      assign rdData[lane*32 +: 32] = laneMem[rdAddr];
    end
  endgenerate

endmodule // dpp_beat_ram

// File: rtl/dpp_link_reset.v
`timescale 1ns/10ps
`include "dpp_map.vh"
module dpp_link_reset (
  // Clock and reset
  input  wire clk,
  input  wire reset,
  // Software restart pulse
  input  wire restart,
  // Reset driven to the slave
  output reg  linkReset
);

  reg [4:0] cnt_reg;

  always @(posedge clk) begin
    if (reset || restart) begin
      cnt_reg   <= 5'h00;
      linkReset <= 1'b1;
    end else if (cnt_reg != `DPP_RST_CYCLES) begin
      cnt_reg   <= cnt_reg + 5'h01;
      linkReset <= 1'b1;
    end else begin
      linkReset <= 1'b0;
    end
  end

endmodule // dpp_link_reset

// File: rtl/dpp_master.v
`timescale 1ns/10ps
`include "dpp_map.vh"
module dpp_master (
  // Clock and reset
  input  wire                      clk,
  input  wire                      reset,
  // Software register port
  input  wire [4:0]                regAddr,
  input  wire [31:0]               regWrData,
  input  wire                      regWrite,
  input  wire                      regRead,
  output reg  [31:0]               regRdData,
  // Master to slave record
  output wire                      m2sClk,
  output wire                      m2sReset,
  output wire [`DPP_NODE_W-1:0]    m2sNodeNumber,
  output reg                       m2sValid,
  output reg                       m2sEop,
  output reg  [`DPP_HDR_W-1:0]     m2sHeader,
  output reg  [`DPP_DATA_W-1:0]    m2sData,
  output wire                      m2sReady,
  // Slave to master record
  input  wire                      s2mValid,
  input  wire                      s2mEop,
  input  wire [`DPP_HDR_W-1:0]     s2mHeader,
  input  wire [`DPP_DATA_W-1:0]    s2mData,
  input  wire                      s2mReady,
  input  wire [`DPP_DROP_W-1:0]    s2mDropCount,
  // Timebase
  output wire                      tbClk,
  output wire                      tbReset
);

  localparam [2:0] TX_RESET = 3'b001;
  localparam [2:0] TX_IDLE  = 3'b010;
  localparam [2:0] TX_SEND  = 3'b100;

  reg  [2:0]               txState_reg;
  reg  [2:0]               txState_next;
  reg  [21:0]              cnt_reg;
  reg  [27:0]              addr_reg;
  reg  [`DPP_NODE_W-1:0]   node_reg;
  reg  [`DPP_PTR_W-1:0]    txPtr_reg;
  reg  [`DPP_PTR_W-1:0]    rxPtr_reg;
  reg  [`DPP_BEAT_AW-1:0]  rxBeat_reg;
  reg  [`DPP_BEAT_AW-1:0]  txBeat_reg;
  reg  [`DPP_CNT_W-1:0]    beatsLeft_reg;
  reg                      goPend_reg;
  reg                      goWrite_reg;
  reg                      rxDone_reg;
  reg                      rspPend_reg;
  reg  [`DPP_HDR_W-1:0]    rspHdr_reg;
  reg  [2:0]               xid_reg;
  reg  [2:0]               lastXid_reg;
  reg  [1:0]               lastOp_reg;
  reg                      inPkt_reg;
  reg  [`DPP_HDR_W-1:0]    inHdr_reg;

  wire                     linkReset;
  wire [`DPP_DATA_W-1:0]   txBeatData;
  wire [`DPP_DATA_W-1:0]   rxBeatData;

  wire wrCmd   = regWrite && (regAddr == `DPP_REG_CMD);
  wire wrCnt   = regWrite && (regAddr == `DPP_REG_CNT);
  wire wrAddr  = regWrite && (regAddr == `DPP_REG_ADDR);
  wire wrTxBuf = regWrite && (regAddr == `DPP_REG_TXBUF);
  wire wrNode  = regWrite && (regAddr == `DPP_REG_NODE);
  wire wrRst   = regWrite && (regAddr == `DPP_REG_RST) && regWrData[0];
  wire rdRxBuf = regRead && (regAddr == `DPP_REG_RXBUF);

  // Busy covers the link reset too, so a GO during reset is refused
  wire busy = goPend_reg || (txState_reg != TX_IDLE);

  // Clock, reset and node number all come from this side
  assign m2sClk        = clk;
  assign m2sReset      = linkReset;
  assign m2sNodeNumber = node_reg;
  assign tbClk         = clk;
  assign tbReset       = linkReset;

  // Receive: one read request may wait for its answer; stall further input until its answer starts to go out
  assign m2sReady = !rspPend_reg && !linkReset;

  wire rxFire = s2mValid && m2sReady;
  wire txFire = m2sValid && s2mReady;

  // Header seen on the first transfer stays valid for the packet
  wire [`DPP_HDR_W-1:0] rxHdr = inPkt_reg ? inHdr_reg : s2mHeader;
  wire [1:0] rxOp = rxHdr[`DPP_H_OP];

  dpp_link_reset uRst (
    .clk       (clk),
    .reset     (reset),
    .restart   (wrRst),
    .linkReset (linkReset)
  );

  // Start of a packet: a pending read response wins over a software request
  wire startRsp = (txState_reg == TX_IDLE) && rspPend_reg;
  wire startGo  = (txState_reg == TX_IDLE) && !rspPend_reg && goPend_reg;

  // A 12-bit count caps one packet at 4096 dwords, which is 16KB
  wire [`DPP_CNT_W-1:0] goCnt  = cnt_reg[`DPP_CR_CNT];
  wire                  goLane = addr_reg[0];
  wire [`DPP_CNT_W-1:0] rsCnt  = rspHdr_reg[`DPP_H_CNT];
  wire                  rsLane = rspHdr_reg[`DPP_H_ADDR_LSB];

  // Last beat index covers the padding lane below an odd dword address
  wire [`DPP_CNT_W:0] goSum = {1'b0, goCnt} + {{`DPP_CNT_W{1'b0}}, goLane};
  wire [`DPP_CNT_W:0] rsSum = {1'b0, rsCnt} + {{`DPP_CNT_W{1'b0}}, rsLane};
  wire [`DPP_CNT_W-1:0] goLast = goSum[`DPP_CNT_W:1];
  wire [`DPP_CNT_W-1:0] rsLast = rsSum[`DPP_CNT_W:1];

  // Response data is taken from the transmit buffer at the requested dword address
  wire [`DPP_BEAT_AW-1:0] rsBase = rspHdr_reg[`DPP_H_ADDR_LSB+1 +: `DPP_BEAT_AW];

  wire [`DPP_BEAT_AW-1:0] txRdAddr = startRsp ? rsBase :
                                     startGo  ? {`DPP_BEAT_AW{1'b0}} :
                                     txBeat_reg + {{(`DPP_BEAT_AW-1){1'b0}}, 1'b1};

  // TXBUF writes fill one dword lane at a time, chosen by the pointer's low bit
  dpp_beat_ram uTxRam (
    .clk    (clk),
    .wrEn   ({txPtr_reg[0], ~txPtr_reg[0]} & {`DPP_WIDTH{wrTxBuf}}),
    .wrAddr (txPtr_reg[`DPP_PTR_W-1:1]),
    .wrData ({regWrData, regWrData}),
    .rdAddr (txRdAddr),
    .rdData (txBeatData)
  );

  wire rxDataBeat = rxFire && (rxOp == `DPP_OP_RESP);

  // Only response beats are stored; a packet longer than the buffer wraps over it
  dpp_beat_ram uRxRam (
    .clk    (clk),
    .wrEn   ({`DPP_WIDTH{rxDataBeat}}),
    .wrAddr (rxBeat_reg),
    .wrData (s2mData),
    .rdAddr (rxPtr_reg[`DPP_PTR_W-1:1]),
    .rdData (rxBeatData)
  );

  // Link reset overrides every state so a restart in mid-packet leaves no residue
  always @* begin
    txState_next = txState_reg;
    case (txState_reg)
      TX_RESET: if (!linkReset) txState_next = TX_IDLE;
      TX_IDLE:  if (startRsp || startGo) txState_next = TX_SEND;
      TX_SEND:  if (txFire && m2sEop) txState_next = TX_IDLE;
      default:  txState_next = TX_RESET;
    endcase
    if (linkReset)
      txState_next = TX_RESET;
  end

  // Transmit engine
  always @(posedge clk) begin
    if (reset || linkReset) begin
      txState_reg   <= TX_RESET;
      m2sValid      <= 1'b0;
      m2sEop        <= 1'b0;
      m2sHeader     <= {`DPP_HDR_W{1'b0}};
      m2sData       <= {`DPP_DATA_W{1'b0}};
      txBeat_reg    <= {`DPP_BEAT_AW{1'b0}};
      beatsLeft_reg <= {`DPP_CNT_W{1'b0}};
      xid_reg       <= 3'h0;
    end else begin
      txState_reg <= txState_next;
      // First beat of a packet comes straight from the buffer read
      if (startRsp) begin
        m2sValid                <= 1'b1;
        m2sHeader               <= rspHdr_reg;
        m2sHeader[`DPP_H_OP]    <= `DPP_OP_RESP;
        m2sData                 <= txBeatData;
        m2sEop                  <= (rsLast == {`DPP_CNT_W{1'b0}});
        beatsLeft_reg           <= rsLast;
        txBeat_reg              <= txRdAddr;
      end else if (startGo) begin
        m2sValid                <= 1'b1;
        m2sHeader[`DPP_H_CNT]   <= goCnt;
        m2sHeader[`DPP_H_XID]   <= xid_reg;
        m2sHeader[`DPP_H_LEAD]  <= cnt_reg[`DPP_CR_LEAD];
        m2sHeader[`DPP_H_TRAIL] <= cnt_reg[`DPP_CR_TRAIL];
        m2sHeader[`DPP_H_NODE]  <= addr_reg[`DPP_AR_NODE];
        m2sHeader[`DPP_H_ADDR]  <= addr_reg[`DPP_AR_ADDR];
        m2sHeader[`DPP_H_EXT]   <= addr_reg[`DPP_AR_EXT];
        txBeat_reg              <= txRdAddr;
        if (goWrite_reg) begin
          m2sHeader[`DPP_H_OP]  <= `DPP_OP_WRITE;
          m2sData               <= txBeatData;
          m2sEop                <= (goLast == {`DPP_CNT_W{1'b0}});
          beatsLeft_reg         <= goLast;
        end else begin
          // Read request is header only, a single transfer
          m2sHeader[`DPP_H_OP]  <= `DPP_OP_READ;
          m2sData               <= {`DPP_DATA_W{1'b0}};
          m2sEop                <= 1'b1;
          beatsLeft_reg         <= {`DPP_CNT_W{1'b0}};
          // Only reads are answered, so only reads take a new number
          xid_reg               <= xid_reg + 3'h1;
        end
      end else if (txFire) begin
        if (m2sEop) begin
          m2sValid <= 1'b0;
          m2sEop   <= 1'b0;
        end else begin
          m2sData       <= txBeatData;
          txBeat_reg    <= txRdAddr;
          beatsLeft_reg <= beatsLeft_reg - {{(`DPP_CNT_W-1){1'b0}}, 1'b1};
          m2sEop        <= (beatsLeft_reg == {{(`DPP_CNT_W-1){1'b0}}, 1'b1});
        end
      end
    end
  end

  // Receive engine
  always @(posedge clk) begin
    if (reset || linkReset) begin
      inPkt_reg   <= 1'b0;
      inHdr_reg   <= {`DPP_HDR_W{1'b0}};
      rxBeat_reg  <= {`DPP_BEAT_AW{1'b0}};
      rspPend_reg <= 1'b0;
      rspHdr_reg  <= {`DPP_HDR_W{1'b0}};
      lastXid_reg <= 3'h0;
      lastOp_reg  <= 2'h0;
    end else begin
      if (startRsp)
        rspPend_reg <= 1'b0;
      if (rxFire) begin
        if (s2mEop) begin
          inPkt_reg   <= 1'b0;
          rxBeat_reg  <= {`DPP_BEAT_AW{1'b0}};
          lastXid_reg <= rxHdr[`DPP_H_XID];
          lastOp_reg  <= rxOp;
          // Incoming writes are absorbed silently; reads queue an answer
          if (rxOp == `DPP_OP_READ) begin
            rspPend_reg <= 1'b1;
            rspHdr_reg  <= rxHdr;
          end
        end else begin
          inPkt_reg <= 1'b1;
          inHdr_reg <= rxHdr;
          if (rxDataBeat)
            rxBeat_reg <= rxBeat_reg + {{(`DPP_BEAT_AW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  wire rspDone = rxFire && s2mEop && (rxOp == `DPP_OP_RESP);

  // Software-facing state
  always @(posedge clk) begin
    if (reset) begin
      cnt_reg     <= `DPP_CNT_RST;
      addr_reg    <= `DPP_ADDR_RST;
      node_reg    <= `DPP_NODE_RST;
      txPtr_reg   <= {`DPP_PTR_W{1'b0}};
      rxPtr_reg   <= {`DPP_PTR_W{1'b0}};
      goPend_reg  <= 1'b0;
      goWrite_reg <= 1'b0;
      rxDone_reg  <= 1'b0;
    end else begin
      if (wrCnt)
        cnt_reg <= regWrData[21:0];
      if (wrAddr) begin
        addr_reg  <= regWrData[27:0];
        txPtr_reg <= {{(`DPP_PTR_W-1){1'b0}}, regWrData[0]};
      end else if (wrTxBuf) begin
        txPtr_reg <= txPtr_reg + {{(`DPP_PTR_W-1){1'b0}}, 1'b1};
      end
      if (wrNode)
        node_reg <= regWrData[`DPP_NODE_W-1:0];
      if (startGo || linkReset)
        goPend_reg <= 1'b0;
      // GO while busy is dropped, not queued: software polls busy before each GO
      else if (wrCmd && regWrData[`DPP_CMD_GO] && !busy) begin
        goPend_reg  <= 1'b1;
        goWrite_reg <= regWrData[`DPP_CMD_WRITE];
        rxPtr_reg   <= {`DPP_PTR_W{1'b0}};
      end
      if (rdRxBuf)
        rxPtr_reg <= rxPtr_reg + {{(`DPP_PTR_W-1){1'b0}}, 1'b1};
      // Completion beats a clear in the same cycle
      if (rspDone)
        rxDone_reg <= 1'b1;
      else if (wrCmd && regWrData[`DPP_CMD_CLRDONE])
        rxDone_reg <= 1'b0;
    end
  end

  // Status words built once; the drop count is already on the port clock, so no synchroniser
  wire [31:0] cmdWord  = {27'h0000000, linkReset, rspPend_reg, goWrite_reg, rxDone_reg, busy};
  wire [31:0] statWord = {16'h0000, xid_reg, lastOp_reg, lastXid_reg, s2mDropCount};
  wire [31:0] rxWord   = rxPtr_reg[0] ? rxBeatData[63:32] : rxBeatData[31:0];

  // Read data stands in the cycle after the strobe only
  always @(posedge clk) begin
    if (reset) begin
      regRdData <= 32'h00000000;
    end else if (regRead) begin
      case (regAddr)
        `DPP_REG_CMD:   regRdData <= cmdWord;
        `DPP_REG_CNT:   regRdData <= {10'h000, cnt_reg};
        `DPP_REG_ADDR:  regRdData <= {4'h0, addr_reg};
        `DPP_REG_RXBUF: regRdData <= rxWord;
        `DPP_REG_STAT:  regRdData <= statWord;
        `DPP_REG_NODE:  regRdData <= {28'h0000000, node_reg};
        default:        regRdData <= 32'h00000000;
      endcase
    end else begin
      regRdData <= 32'h00000000;
    end
  end

endmodule // dpp_master

// File: shared/dpp_map.vh
`ifndef DPP_MAP_VH
`define DPP_MAP_VH

// Link geometry
`define DPP_WIDTH        2
`define DPP_DATA_W       64
`define DPP_HDR_W        39
`define DPP_CNT_W        12
`define DPP_BEAT_AW      4
`define DPP_PTR_W        5
`define DPP_NODE_W       4
`define DPP_DROP_W       8

// Header field positions
`define DPP_H_CNT        11:0
`define DPP_H_OP         13:12
`define DPP_H_XID        16:14
`define DPP_H_LEAD       18:17
`define DPP_H_TRAIL      20:19
`define DPP_H_NODE       24:21
`define DPP_H_ADDR       34:25
`define DPP_H_EXT        38:35
`define DPP_H_ADDR_LSB   25

// Operations
`define DPP_OP_READ      2'h0
`define DPP_OP_WRITE     2'h1
`define DPP_OP_RESP      2'h2

// Link reset stays high for this many clock cycles plus one
`define DPP_RST_CYCLES   5'h10

// Register byte offsets
`define DPP_REG_CMD      5'h00
`define DPP_REG_CNT      5'h04
`define DPP_REG_ADDR     5'h08
`define DPP_REG_TXBUF    5'h0c
`define DPP_REG_RXBUF    5'h10
`define DPP_REG_STAT     5'h14
`define DPP_REG_NODE     5'h18
`define DPP_REG_RST      5'h1c

// Command register bits
`define DPP_CMD_GO       0
`define DPP_CMD_CLRDONE  1
`define DPP_CMD_WRITE    2

// Count register fields
`define DPP_CR_CNT       11:0
`define DPP_CR_LEAD      17:16
`define DPP_CR_TRAIL     21:20

// Address register fields
`define DPP_AR_ADDR      9:0
`define DPP_AR_EXT       19:16
`define DPP_AR_NODE      27:24

// Reset values
`define DPP_CNT_RST      22'h000000
`define DPP_ADDR_RST     28'h0000000
`define DPP_NODE_RST     4'h0

`endif

// File: test/data_plane_packet_port_test.sv
`timescale 1ns/10ps
`include "dpp_map.vh"
module data_plane_packet_port_test;
  typedef struct packed {
    logic [63:0] d;
    logic [63:0] m;
    logic [38:0] h;
  } dpp_beat_t;
  // Transaction numbering is the design's own choice, so beats skip it
  localparam logic [38:0] XMASK = {22'h3fffff, 3'h0, 14'h3fff};
  reg          clk = 1'b0;
  reg          reset = 1'b1;
  reg  [4:0]   regAddr = 5'h00;
  reg  [31:0]  regWrData = 32'h0;
  reg          regWrite = 1'b0;
  reg          regRead = 1'b0;
  reg          rdChk = 1'b0;
  reg          rdDly = 1'b0;
  reg          chkDly = 1'b0;
  reg          stall = 1'b0;
  reg          stallOn = 1'b0;
  reg          reqGo = 1'b0;
  reg  [38:0]  reqHdr = 39'h0;
  reg  [7:0]   dropIn = 8'h00;
  reg  [31:0]  lastRd;
  wire [31:0]  regRdData;
  wire         m2sReset, m2sValid, m2sEop, m2sReady, s2mValid, s2mEop, s2mReady;
  wire [3:0]   m2sNodeNumber;
  wire [38:0]  m2sHeader, s2mHeader;
  wire [63:0]  m2sData, s2mData;
  wire [7:0]   s2mDropCount;
  wire         m2sClk, tbClk, tbReset;
  logic [31:0] regQ[$];
  dpp_beat_t   beatQ[$];
  dpp_beat_t   eb;
  int          mismatches = 0;
  int          numChecks = 0;
  int          cyc = 0;
  dpp_master uut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .m2sClk(m2sClk), .m2sReset(m2sReset), .m2sNodeNumber(m2sNodeNumber),
    .m2sValid(m2sValid), .m2sEop(m2sEop), .m2sHeader(m2sHeader), .m2sData(m2sData), .m2sReady(m2sReady),
    .s2mValid(s2mValid), .s2mEop(s2mEop), .s2mHeader(s2mHeader), .s2mData(s2mData), .s2mReady(s2mReady),
    .s2mDropCount(s2mDropCount), .tbClk(tbClk), .tbReset(tbReset));
  dpp_slave_model pm (.clk(clk), .linkReset(m2sReset), .m2sValid(m2sValid), .m2sEop(m2sEop),
    .m2sHeader(m2sHeader), .m2sReady(m2sReady), .s2mValid(s2mValid), .s2mEop(s2mEop), .s2mHeader(s2mHeader),
    .s2mData(s2mData), .s2mReady(s2mReady), .s2mDropCount(s2mDropCount), .stall(stall), .reqGo(reqGo),
    .reqHdr(reqHdr), .dropIn(dropIn));
  always #5 clk = ~clk;
  function logic [38:0] hdr(input [11:0] c, input [1:0] op, input [1:0] ld, input [1:0] tr, input [3:0] nd);
    hdr = {14'h0, nd, tr, ld, 3'h0, op, c};
  endfunction
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task testDone;
    $display("checks=%0d mismatches=%0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task acc(input [4:0] a, input [31:0] d, input w, input c);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= w;
    regRead <= !w;
    rdChk <= c;
    if (c)
      regQ.push_back(d);
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    rdChk <= 1'b0;
  endtask
  task waitReg(input [4:0] a, input [31:0] m, input [31:0] v);
    int n;
    n = 0;
    do begin
      acc(a, 32'h0, 1'b0, 1'b0);
      @(posedge clk);
      #1;
      n++;
    end while ((lastRd & m) !== v && n < 200);
    chk(lastRd & m, v);
  endtask
  task send(input [38:0] h);
    int n;
    @(posedge clk);
    reqHdr <= h;
    reqGo <= 1'b1;
    @(posedge clk);
    reqGo <= 1'b0;
    for (n = 0; n < 200 && (s2mValid || n == 0); n++)
      @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rdDly)
      lastRd = regRdData;
    if (rdDly && chkDly)
      chk(regRdData, regQ.pop_front());
    rdDly <= regRead;
    chkDly <= rdChk;
    stall <= stallOn && ($urandom % 3 == 0);
    if (m2sValid && s2mReady && beatQ.size() == 0)
      chk(m2sHeader, 64'h0);
    else if (m2sValid && s2mReady) begin
      eb = beatQ.pop_front();
      chk(m2sData & eb.m, eb.d & eb.m);
      chk(m2sHeader & XMASK, eb.h);
    end
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      testDone;
    end
  end
  logic [31:0] t[4];
  logic [4:0]  zr[5] = '{`DPP_REG_CNT, `DPP_REG_ADDR, `DPP_REG_NODE, 5'h1e, `DPP_REG_STAT};
  logic [7:0]  drop;
  initial begin
    void'($urandom(6));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // Engine reads busy while the link is held in reset
    acc(`DPP_REG_CMD, 32'h11, 1'b0, 1'b1);
    waitReg(`DPP_REG_CMD, 32'h10, 32'h0);
    chk({m2sClk, tbClk, tbReset}, 64'h6);
    foreach (zr[i])
      acc(zr[i], 32'h0, 1'b0, 1'b1);
    t[0] = $urandom;
    acc(`DPP_REG_NODE, {28'h0, t[0][3:0]}, 1'b1, 1'b0);
    acc(`DPP_REG_NODE, {28'h0, t[0][3:0]}, 1'b0, 1'b1);
    chk(m2sNodeNumber, t[0][3:0]);
    drop = $urandom;
    dropIn <= drop;
    acc(`DPP_REG_STAT, {24'h0, drop}, 1'b0, 1'b1);
    stallOn <= 1'b1;
    t[0] = $urandom;
    t[1] = $urandom;
    acc(`DPP_REG_CNT, 32'h00210001, 1'b1, 1'b0);
    acc(`DPP_REG_ADDR, 32'h03000001, 1'b1, 1'b0);
    acc(`DPP_REG_TXBUF, t[0], 1'b1, 1'b0);
    acc(`DPP_REG_TXBUF, t[1], 1'b1, 1'b0);
    beatQ.push_back('{{t[0], 32'h0}, {32'hffffffff, 32'h0}, hdr(12'h1, `DPP_OP_WRITE, 2'h1, 2'h2, 4'h3) | 39'h2000000});
    beatQ.push_back('{{32'h0, t[1]}, {32'h0, 32'hffffffff}, hdr(12'h1, `DPP_OP_WRITE, 2'h1, 2'h2, 4'h3) | 39'h2000000});
    acc(`DPP_REG_CMD, 32'h5, 1'b1, 1'b0);
    waitReg(`DPP_REG_CMD, 32'h1, 32'h0);
    acc(`DPP_REG_CNT, 32'h2, 1'b1, 1'b0);
    acc(`DPP_REG_ADDR, 32'h05000000, 1'b1, 1'b0);
    beatQ.push_back('{64'h0, 64'h0, hdr(12'h2, `DPP_OP_READ, 2'h0, 2'h0, 4'h5)});
    acc(`DPP_REG_CMD, 32'h1, 1'b1, 1'b0);
    waitReg(`DPP_REG_CMD, 32'h2, 32'h2);
    for (int i = 0; i < 3; i++)
      acc(`DPP_REG_RXBUF, 32'hb0000000 | i, 1'b0, 1'b1);
    acc(`DPP_REG_CMD, 32'h2, 1'b0, 1'b1);
    acc(`DPP_REG_STAT, {16'h0, 3'h1, 2'h2, 3'h0, drop}, 1'b0, 1'b1);
    acc(`DPP_REG_CMD, 32'h2, 1'b1, 1'b0);
    acc(`DPP_REG_CMD, 32'h0, 1'b0, 1'b1);
    acc(`DPP_REG_ADDR, 32'h0, 1'b1, 1'b0);
    foreach (t[i]) begin
      t[i] = $urandom;
      acc(`DPP_REG_TXBUF, t[i], 1'b1, 1'b0);
    end
    beatQ.push_back('{{t[1], t[0]}, '1, hdr(12'h3, `DPP_OP_RESP, 2'h0, 2'h0, 4'h7)});
    beatQ.push_back('{{t[3], t[2]}, '1, hdr(12'h3, `DPP_OP_RESP, 2'h0, 2'h0, 4'h7)});
    send(hdr(12'h3, `DPP_OP_READ, 2'h0, 2'h0, 4'h7));
    send(hdr(12'h0, `DPP_OP_WRITE, 2'h0, 2'h0, 4'h7));
    for (int i = 0; i < 300 && beatQ.size() != 0; i++)
      @(posedge clk);
    acc(`DPP_REG_RST, 32'h1, 1'b1, 1'b0);
    acc(`DPP_REG_CMD, 32'h11, 1'b0, 1'b1);
    waitReg(`DPP_REG_CMD, 32'h10, 32'h0);
    chk(beatQ.size(), 64'h0);
    testDone;
  end
endmodule // data_plane_packet_port_test

// File: test/dpp_master_checker.sv
`timescale 1ns/10ps
`include "dpp_map.vh"
module dpp_master_checker (
  // Clock and reset
  input wire                   clk,
  input wire                   reset,
  // Link
  input wire                   m2sReset,
  input wire                   m2sValid,
  input wire                   m2sEop,
  input wire [`DPP_HDR_W-1:0]  m2sHeader,
  input wire [`DPP_DATA_W-1:0] m2sData,
  input wire                   m2sReady,
  input wire                   s2mValid,
  input wire                   s2mEop,
  input wire [`DPP_HDR_W-1:0]  s2mHeader,
  input wire                   s2mReady
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  reg [7:0]            hiCnt_reg;
  reg                  inPkt_reg;
  reg [`DPP_HDR_W-1:0] hdrKeep_reg;
  wire                 txAcc = m2sValid && s2mReady;
  wire                 rxEnd = s2mValid && m2sReady && s2mEop;
  // Counts only while link reset is high, so a long core reset cannot mask a short link reset
  always @(posedge clk) begin
    if (reset || !m2sReset)
      hiCnt_reg <= 8'h00;
    else if (hiCnt_reg != 8'hff)
      hiCnt_reg <= hiCnt_reg + 8'h01;
    if (reset || m2sReset)
      inPkt_reg <= 1'b0;
    else if (txAcc)
      inPkt_reg <= !m2sEop;
    if (txAcc && !inPkt_reg)
      hdrKeep_reg <= m2sHeader;
  end
  property p_rst_len;
    $fell(m2sReset) |-> hiCnt_reg >= 8'h10;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("link reset too short");
  property p_rst_quiet;
    m2sReset |-> !m2sReady ##1 !m2sValid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("link busy in reset");
  property p_hold;
    disable iff (reset || m2sReset) m2sValid && !s2mReady |=>
      m2sValid && $stable(m2sEop) && $stable(m2sData) && $stable(m2sHeader);
  endproperty
  a_hold: assert property (p_hold) else $error("transfer changed while stalled");
  property p_hdr;
    inPkt_reg && m2sValid |-> m2sHeader == hdrKeep_reg;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header changed inside packet");
  property p_eop_gap;
    txAcc && m2sEop |=> !m2sValid;
  endproperty
  a_eop_gap: assert property (p_eop_gap) else $error("no gap after last transfer");
  property p_rd_answer;
    rxEnd && s2mHeader[`DPP_H_OP] == `DPP_OP_READ |=>
      !m2sReady ##[0:200] (m2sValid && m2sHeader[`DPP_H_OP] == `DPP_OP_RESP);
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_wr_posted;
    rxEnd && s2mHeader[`DPP_H_OP] == `DPP_OP_WRITE |=> m2sReady;
  endproperty
  a_wr_posted: assert property (p_wr_posted) else $error("write held off input");
  property p_resp_ready;
    txAcc && m2sEop && m2sHeader[`DPP_H_OP] == `DPP_OP_RESP |=> m2sReady;
  endproperty
  a_resp_ready: assert property (p_resp_ready) else $error("input not reopened");
endmodule // dpp_master_checker
bind dpp_master dpp_master_checker u_chk (.clk(clk), .reset(reset), .m2sReset(m2sReset), .m2sValid(m2sValid),
  .m2sEop(m2sEop), .m2sHeader(m2sHeader), .m2sData(m2sData), .m2sReady(m2sReady), .s2mValid(s2mValid),
  .s2mEop(s2mEop), .s2mHeader(s2mHeader), .s2mReady(s2mReady));

// File: test/dpp_slave_model.sv
`timescale 1ns/10ps
`include "dpp_map.vh"
module dpp_slave_model (
  // Clock and link reset
  input  wire                   clk,
  input  wire                   linkReset,
  // Master to slave record
  input  wire                   m2sValid,
  input  wire                   m2sEop,
  input  wire [`DPP_HDR_W-1:0]  m2sHeader,
  input  wire                   m2sReady,
  // Slave to master record
  output reg                    s2mValid,
  output reg                    s2mEop,
  output reg  [`DPP_HDR_W-1:0]  s2mHeader,
  output reg  [`DPP_DATA_W-1:0] s2mData,
  output wire                   s2mReady,
  output wire [`DPP_DROP_W-1:0] s2mDropCount,
  // Bench controls
  input  wire                   stall,
  input  wire                   reqGo,
  input  wire [`DPP_HDR_W-1:0]  reqHdr,
  input  wire [`DPP_DROP_W-1:0] dropIn
);
  reg  [11:0]           left_reg;
  reg  [15:0]           beat_reg;
  reg                   due_reg;
  reg  [`DPP_HDR_W-1:0] rsp_reg;
  wire [15:0]           nb = beat_reg + 16'h1;
  wire [11:0]           nBeats = ((rsp_reg[`DPP_H_CNT] + {11'h0, rsp_reg[`DPP_H_ADDR_LSB]}) >> 1) + 12'h1;
  assign s2mReady     = !stall && !linkReset;
  assign s2mDropCount = dropIn;
  always @(posedge clk) begin
    if (linkReset) begin
      s2mValid <= 1'b0;
      due_reg  <= 1'b0;
    end else begin
      if (s2mValid && m2sReady) begin
        s2mValid <= !s2mEop;
        s2mEop   <= left_reg == 12'h2;
        left_reg <= left_reg - 12'h1;
        beat_reg <= nb;
        s2mData  <= {16'hb000, nb[14:0], 1'b1, 16'hb000, nb[14:0], 1'b0};
      end else if (!s2mValid && due_reg && !stall) begin
        s2mValid  <= 1'b1;
        s2mEop    <= nBeats == 12'h1;
        s2mHeader <= {rsp_reg[38:14], `DPP_OP_RESP, rsp_reg[11:0]};
        left_reg  <= nBeats;
        beat_reg  <= 16'h0;
        s2mData   <= {32'hb0000001, 32'hb0000000};
        due_reg   <= 1'b0;
      end else if (!s2mValid && reqGo) begin
        s2mValid  <= 1'b1;
        s2mEop    <= 1'b1;
        s2mHeader <= reqHdr;
        s2mData   <= 64'h0;
      end else if (!s2mValid) begin
        // Idle lines keep moving so stale values never look like data
        s2mEop    <= ~s2mEop;
        s2mHeader <= ~s2mHeader;
        s2mData   <= ~s2mData;
      end
      if (m2sValid && s2mReady && m2sEop && m2sHeader[`DPP_H_OP] == `DPP_OP_READ) begin
        due_reg <= 1'b1;
        rsp_reg <= m2sHeader;
      end
    end
  end
endmodule // dpp_slave_model
